// *** spi_hc_map.svh ***
// Purpose: Register offsets, field positions, field codes and timing counts of the dual-role serial port.
// Assumes: Byte offsets, not all word aligned, on a plain strobe port with 32-bit data.
// Notes: Definitions only; included by the design, the checker and the bench.
`ifndef SPI_HC_MAP_SVH
`define SPI_HC_MAP_SVH
`define SPI_CTRLA_OFS 8'h00
`define SPI_CTRLB_OFS 8'h04
`define SPI_BAUD_OFS 8'h0A
`define SPI_IEN_CLR_OFS 8'h0C
`define SPI_IEN_SET_OFS 8'h0D
`define SPI_IFLAG_OFS 8'h0E
`define SPI_STATUS_OFS 8'h10
`define SPI_ADDR_OFS 8'h14
`define SPI_DATA_OFS 8'h18
`define SPI_SLEEP_OFS 8'h1C
`define SPI_A_SOFT_RESET_BIT 0
`define SPI_A_ENABLE 1
`define SPI_A_MODE_LO 2
`define SPI_A_RUNSTBY 7
`define SPI_A_IMMOVF 8
`define SPI_A_TXPAD_LO 16
`define SPI_A_RXPAD_LO 20
`define SPI_A_FRAME_FORMAT_FIELD_LO 24
`define SPI_A_PHASE 28
`define SPI_A_POL 29
`define SPI_A_ORDER 30
`define SPI_B_CSIZE_LO 0
`define SPI_B_PRELOAD 6
`define SPI_B_RECEIVER_ENABLE_BIT 17
`define SPI_F_TXE 0
`define SPI_F_TXC 1
`define SPI_F_RXC 2
`define SPI_S_OVF 2
`define SPI_S_BUSY 15
`define SPI_MODE_CLIENT 3'h2
`define SPI_MODE_HOST 3'h3
`define SPI_FRAME_FORMAT_FIELD_ADDR 4'h2
`define SPI_CSIZE_9 3'h1
`define SPI_TXE_DELAY 2'h3
`define SPI_CLIENT_LEAD 4'h3
`endif

// *** spi_hc_pkg.sv ***
// Purpose: Types shared by the dual-role serial port.
// Assumes: Constants live in the map header.
// Notes: Types only.
package spi_hc_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_GAP} xfer_state_t;
  typedef logic [8:0] char_t;
endpackage

// *** spi_host_client_transfer.sv ***
// Purpose: Dual-role serial port with transfer flags, overflow error, address match and preload.
// Assumes: One system clock; data pin passes two flip-flops, clock and select pins three; pads resolved by the bench.
// Notes: Core and bus domains are one clock here; the enable crossing is a two-stage delay.
// Behaviour
// - Data move to shifter sets empty flag
// - Last bit copies into receive buffer
// - Host done when shifted and none waiting
// - Client idle, output released while deselected
// - Client deselect sets transmit done
// - Client written data needs three clock lead
// - Late client write sends received character
// - Empty flag rises three cycles after emptying
// - Overflow sticky, cleared by one or disable
// - Immediate mode raises overflow at once
// - Deferred overflow travels, data reads zero
// - Client address match accepts transaction
// - Address mismatch ignores whole transaction
// - Nine-bit address compares low eight bits
// - Client first shifts existing shifter contents
// - Preload takes one character while deselected
// - Same pads loop transmit data back
// - Three flags, set/clear enables, one request
// - Host sleep stops after transfer finishes
// - Client sleep without standby drops reception
// - Reset, enable, receive enable are synchronised
// - Polarity and phase choose sampling edge
// - Characters eight or nine bits
// - Order bit picks first bit
`timescale 1ns/1ps
`include "spi_hc_map.svh"
module spi_host_client_transfer #(
  parameter int DW = 32
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Register port.
  input wire logic [7:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DW-1:0] rdata_o,
  // Sleep request and request line.
  input wire logic sleep_i,
  output logic irq_o,
  output logic wake_o,
  // Host select general purpose output.
  output logic sel_out_o,
  // Serial pins as in, out, enable; the select pin is input only.
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  input wire logic sel_i,
  input wire logic [3:0] pad_i,
  output logic [3:0] pad_o,
  output logic [3:0] pad_oe_o
);
  import spi_hc_pkg::*;

  logic [31:0] ctrla_r, ctrlb_r, addr_r;
  logic [7:0] baud_r;
  logic [2:0] ien_r, flag_r;
  logic ovf_r, sel_out_r;
  logic [1:0] en_sync_r, receiver_enable_bit_sync_r, rst_sync_r;
  logic [8:0] tx_hold_r;
  logic tx_valid_r;
  logic [3:0] tx_age_r;
  logic [1:0] txe_cnt_r;
  char_t shreg_r, rx_buf_r [2];
  logic [1:0] rx_ovf_q_r;
  logic [1:0] rx_cnt_r;
  logic [3:0] bit_r;
  logic preloaded_r, addr_ok_r, first_r, ignore_r;
  xfer_state_t st_r;
  logic [7:0] div_r;
  logic sck_int_r, phase_r, sleeping_r, tx_bit_r, hold_out_r, core_stop_r;
  logic [2:0] sck_s_r, sel_s_r;
  logic [1:0] din_s_r;
  logic [31:0] rdata_r;

  wire logic is_host = ctrla_r[`SPI_A_MODE_LO +: 3] == `SPI_MODE_HOST;
  wire logic is_client = ctrla_r[`SPI_A_MODE_LO +: 3] == `SPI_MODE_CLIENT;
  wire logic enabled = en_sync_r[1];
  wire logic rx_on = receiver_enable_bit_sync_r[1];
  wire logic nine = ctrlb_r[`SPI_B_CSIZE_LO +: 3] == `SPI_CSIZE_9;
  wire logic [3:0] nbits = nine ? 4'h9 : 4'h8;
  wire logic clock_polarity = ctrla_r[`SPI_A_POL];
  wire logic clock_phase = ctrla_r[`SPI_A_PHASE];
  wire logic [1:0] rxpad = ctrla_r[`SPI_A_RXPAD_LO +: 2];
  wire logic [1:0] txpad = ctrla_r[`SPI_A_TXPAD_LO +: 2];
  wire logic wr_data = wr_i && addr_i == `SPI_DATA_OFS;
  wire logic rd_data = rd_i && addr_i == `SPI_DATA_OFS;
  wire logic locked = ctrla_r[`SPI_A_ENABLE];

  // Bit that leaves next, per order setting.
  function automatic logic out_bit(input char_t s, input logic lsb, input logic n9);
    out_bit = lsb ? s[0] : (n9 ? s[8] : s[7]);
  endfunction

  // Shift one bit in from the correct end.
  function automatic char_t shift_in(input char_t s, input logic b, input logic lsb, input logic n9);
    if (lsb)
      shift_in = n9 ? {b, s[8:1]} : {1'b0, b, s[7:1]};
    else
      shift_in = n9 ? {s[7:0], b} : {1'b0, s[6:0], b};
  endfunction

  // Control registers; enable-protected fields are frozen while enabled.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i || rst_sync_r[1])
    begin
      ctrla_r <= 32'h0;
      ctrlb_r <= 32'h0;
      baud_r <= 8'h0;
      addr_r <= 32'h0;
      ien_r <= 3'h0;
      sel_out_r <= 1'b1;
      sleeping_r <= 1'b0;
    end
    else if (wr_i)
    begin
      case (addr_i)
        `SPI_CTRLA_OFS: ctrla_r <= locked ? {ctrla_r[31:2], wdata_i[1:0]} : wdata_i;
        `SPI_CTRLB_OFS: ctrlb_r <= locked ? {ctrlb_r[31:18], wdata_i[17], ctrlb_r[16:0]} : wdata_i;
        `SPI_BAUD_OFS: baud_r <= locked ? baud_r : wdata_i[7:0];
        `SPI_ADDR_OFS: addr_r <= locked ? addr_r : wdata_i;
        `SPI_IEN_SET_OFS: ien_r <= ien_r | wdata_i[2:0];
        `SPI_IEN_CLR_OFS: ien_r <= ien_r & ~wdata_i[2:0];
        `SPI_SLEEP_OFS:
        begin
          sel_out_r <= wdata_i[0];
          sleeping_r <= wdata_i[1];
        end
        default: ;
      endcase
    end
  end

  // Control bits cross into the core side before acting.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      en_sync_r <= 2'h0;
      receiver_enable_bit_sync_r <= 2'h0;
      rst_sync_r <= 2'h0;
    end
    else
    begin
      en_sync_r <= {en_sync_r[0], ctrla_r[`SPI_A_ENABLE]};
      receiver_enable_bit_sync_r <= {receiver_enable_bit_sync_r[0], ctrlb_r[`SPI_B_RECEIVER_ENABLE_BIT]};
      rst_sync_r <= {rst_sync_r[0], ctrla_r[`SPI_A_SOFT_RESET_BIT] & ~rst_sync_r[0]};
    end
  end

  // Pin synchronisers; only the second stage and later are read.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      sck_s_r <= 3'h0;
      sel_s_r <= 3'h7;
      din_s_r <= 2'h0;
    end
    else
    begin
      sck_s_r <= {sck_s_r[1:0], sck_i};
      sel_s_r <= {sel_s_r[1:0], sel_i};
      din_s_r <= {din_s_r[0], pad_i[rxpad]};
    end
  end

  // Edges seen on the serial clock: host uses its own, client the pin.
  wire logic sel_low = !sel_s_r[2];
  wire logic sel_rise = sel_s_r[2:1] == 2'b01;
  wire logic c_lead = sck_s_r[2:1] == (clock_polarity ? 2'b10 : 2'b01);
  wire logic c_trail = sck_s_r[2:1] == (clock_polarity ? 2'b01 : 2'b10);
  wire logic tick = div_r == baud_r;
  wire logic h_lead = tick && !phase_r && st_r == ST_SHIFT;
  wire logic h_trail = tick && phase_r && st_r == ST_SHIFT;
  wire logic lead = is_host ? h_lead : c_lead && sel_low;
  wire logic trail = is_host ? h_trail : c_trail && sel_low;
  wire logic samp = clock_phase ? trail : lead;
  wire logic setup = clock_phase ? lead : trail;
  wire logic last = samp && bit_r == nbits - 4'h1;
  wire logic sleep_drop = is_client && sleeping_r && !ctrla_r[`SPI_A_RUNSTBY];
  wire logic active = enabled && !sleep_drop && !core_stop_r && !(is_client && ignore_r);
  wire logic fresh = tx_age_r >= `SPI_CLIENT_LEAD;
  wire logic load_ok = tx_valid_r && (is_host || fresh);
  wire logic preload = is_client && ctrlb_r[`SPI_B_PRELOAD] && !sel_low && !preloaded_r && tx_valid_r;
  wire logic addr_frame_format_field = ctrla_r[`SPI_A_FRAME_FORMAT_FIELD_LO +: 4] == `SPI_FRAME_FORMAT_FIELD_ADDR;
  wire logic ovf_now = last && rx_on && rx_cnt_r == 2'h2;
  wire char_t rx_in = shift_in(shreg_r, din_s_r[1], ctrla_r[`SPI_A_ORDER], nine);
  wire logic addr_hit = rx_in[7:0] == addr_r[7:0];

  // Transmit holding register and the age of its content in client clock edges.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i || rst_sync_r[1])
    begin
      tx_hold_r <= 9'h0;
      tx_valid_r <= 1'b0;
      tx_age_r <= 4'h0;
    end
    else if (wr_data)
    begin
      tx_hold_r <= wdata_i[8:0];
      tx_valid_r <= 1'b1;
      tx_age_r <= 4'h0;
    end
    else
    begin
      if (preload || (is_client && active && st_r != ST_IDLE && bit_r == 4'h0 && setup && !first_r && load_ok) ||
          (is_host && active && tx_valid_r && (st_r == ST_IDLE || (st_r == ST_GAP && tick))))
        tx_valid_r <= 1'b0;
      if (c_lead && !fresh)
        tx_age_r <= tx_age_r + 4'h1;
    end
  end

  // Shift engine and transaction state.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i || rst_sync_r[1])
    begin
      st_r <= ST_IDLE;
      shreg_r <= 9'h0;
      bit_r <= 4'h0;
      div_r <= 8'h0;
      sck_int_r <= 1'b0;
      phase_r <= 1'b0;
      preloaded_r <= 1'b0;
      first_r <= 1'b1;
      addr_ok_r <= 1'b0;
      ignore_r <= 1'b0;
    end
    else
    begin
      div_r <= (tick || st_r == ST_IDLE) ? 8'h0 : div_r + 8'h1;
      if (preload)
      begin
        shreg_r <= tx_hold_r;
        preloaded_r <= 1'b1;
      end
      if (is_client && sel_rise)
      begin
        st_r <= ST_IDLE;
        bit_r <= 4'h0;
        first_r <= 1'b1;
        ignore_r <= 1'b0;
        addr_ok_r <= 1'b0;
        preloaded_r <= 1'b0;
      end
      else if (!active)
      begin
        if (is_host)
          st_r <= ST_IDLE;
        sck_int_r <= clock_polarity;
      end
      else
      begin
        case (st_r)
          ST_IDLE:
          begin
            sck_int_r <= clock_polarity;
            bit_r <= 4'h0;
            phase_r <= 1'b0;
            if (is_host && tx_valid_r)
            begin
              shreg_r <= tx_hold_r;
              st_r <= ST_SHIFT;
            end
            else if (is_client && sel_low)
              st_r <= ST_SHIFT;
          end
          ST_SHIFT:
          begin
            if (is_host && tick)
            begin
              sck_int_r <= ~sck_int_r;
              phase_r <= ~phase_r;
            end
            if (samp)
            begin
              shreg_r <= rx_in;
              bit_r <= last ? 4'h0 : bit_r + 4'h1;
              if (last)
              begin
                first_r <= 1'b0;
                if (is_client && addr_frame_format_field && first_r)
                begin
                  addr_ok_r <= addr_hit;
                  ignore_r <= !addr_hit;
                end
                if (is_host && !clock_phase)
                  st_r <= ST_GAP;
              end
            end
            if (is_client && setup && bit_r == 4'h0 && !first_r && load_ok)
              shreg_r <= tx_hold_r;
            if (is_host && clock_phase && h_trail && bit_r == nbits - 4'h1)
              st_r <= ST_GAP;
          end
          ST_GAP:
          begin
            if (tick || !is_host)
            begin
              sck_int_r <= clock_polarity;
              phase_r <= 1'b0;
              if (tx_valid_r)
              begin
                shreg_r <= tx_hold_r;
                st_r <= ST_SHIFT;
              end
              else
                st_r <= ST_IDLE;
            end
          end
          default: st_r <= ST_IDLE;
        endcase
      end
    end
  end

  // Two-level receive buffer; each entry carries its own overflow mark.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i || rst_sync_r[1] || !rx_on)
    begin
      rx_cnt_r <= 2'h0;
      rx_buf_r[0] <= 9'h0;
      rx_buf_r[1] <= 9'h0;
      rx_ovf_q_r <= 2'h0;
    end
    else
    begin
      if (rd_data && rx_cnt_r != 2'h0)
      begin
        rx_buf_r[0] <= rx_buf_r[1];
        rx_ovf_q_r <= {1'b0, rx_ovf_q_r[1]};
        rx_cnt_r <= rx_cnt_r - 2'h1;
      end
      if (last && active && !(addr_frame_format_field && is_client && first_r && !addr_hit))
      begin
        if (rx_cnt_r == 2'h2 && !ctrla_r[`SPI_A_IMMOVF] && !rd_data)
          rx_ovf_q_r[1] <= 1'b1;
        else if (rx_cnt_r == 2'h2 || (rx_cnt_r == 2'h1 && !rd_data))
        begin
          rx_buf_r[1] <= rx_in;
          rx_cnt_r <= 2'h2;
        end
        else
        begin
          rx_buf_r[rd_data ? 0 : rx_cnt_r[0]] <= rx_in;
          rx_cnt_r <= rd_data ? rx_cnt_r : rx_cnt_r + 2'h1;
        end
      end
    end
  end

  // Delay from the holding register emptying to its empty flag.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i || tx_valid_r)
      txe_cnt_r <= 2'h0;
    else if (txe_cnt_r != `SPI_TXE_DELAY)
      txe_cnt_r <= txe_cnt_r + 2'h1;
  end

  // Flags; a hardware set wins over a software clear in the same cycle.
  wire logic host_done = is_host && st_r == ST_GAP && !tx_valid_r && (tick);
  wire logic set_txc = host_done || (is_client && sel_rise);
  wire logic txe_set = txe_cnt_r == `SPI_TXE_DELAY - 2'h1;
  wire logic flag_clr_wr = wr_i && addr_i == `SPI_IFLAG_OFS;
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i || rst_sync_r[1])
    begin
      flag_r <= 3'h0;
      ovf_r <= 1'b0;
    end
    else
    begin
      flag_r[`SPI_F_TXE] <= txe_set || (flag_r[`SPI_F_TXE] && !wr_data);
      flag_r[`SPI_F_TXC] <= set_txc || (flag_r[`SPI_F_TXC] && !(flag_clr_wr && wdata_i[`SPI_F_TXC]));
      flag_r[`SPI_F_RXC] <= rx_on && (rx_cnt_r != 2'h0 || rx_ovf_q_r[0]);
      if (!rx_on)
        ovf_r <= 1'b0;
      else if ((ovf_now && ctrla_r[`SPI_A_IMMOVF]) || (rd_data && rx_ovf_q_r[0]))
        ovf_r <= 1'b1;
      else if (wr_i && addr_i == `SPI_STATUS_OFS && wdata_i[`SPI_S_OVF])
        ovf_r <= 1'b0;
    end
  end

  // Read data stands in the cycle after the read strobe.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      rdata_r <= 32'h0;
    else if (rd_i)
    begin
      case (addr_i)
        `SPI_CTRLA_OFS: rdata_r <= ctrla_r;
        `SPI_CTRLB_OFS: rdata_r <= ctrlb_r;
        `SPI_BAUD_OFS: rdata_r <= {24'h0, baud_r};
        `SPI_IEN_SET_OFS, `SPI_IEN_CLR_OFS: rdata_r <= {29'h0, ien_r};
        `SPI_IFLAG_OFS: rdata_r <= {29'h0, flag_r};
        `SPI_STATUS_OFS: rdata_r <= {16'h0, en_sync_r[1] != ctrla_r[`SPI_A_ENABLE], 12'h0, ovf_r, 2'h0};
        `SPI_ADDR_OFS: rdata_r <= addr_r;
        `SPI_DATA_OFS: rdata_r <= rx_ovf_q_r[0] ? 32'h0 : {23'h0, rx_buf_r[0]};
        `SPI_SLEEP_OFS: rdata_r <= {30'h0, sleeping_r, sel_out_r};
        default: rdata_r <= 32'h0;
      endcase
    end
  end

  // Launch register of the data pad: after a sample edge the old bit is held until the setup edge,
  // so the far side never sees the data move on its own sampling edge. A divider of zero leaves no margin.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i || rst_sync_r[1])
    begin
      tx_bit_r <= 1'b0;
      hold_out_r <= 1'b0;
    end
    else
    begin
      if (!hold_out_r || setup || st_r != ST_SHIFT)
        tx_bit_r <= out_bit(shreg_r, ctrla_r[`SPI_A_ORDER], nine);
      if (samp && st_r == ST_SHIFT)
        hold_out_r <= 1'b1;
      else if (setup || st_r != ST_SHIFT)
        hold_out_r <= 1'b0;
    end
  end

  // Outputs: host clock, select output, and the data pad; pads loop back outside.
  wire logic drive_miso = is_client && sel_low && enabled && !ignore_r && (!addr_frame_format_field || addr_ok_r || first_r);
  always_comb
  begin
    pad_o = 4'h0;
    pad_oe_o = 4'h0;
    pad_o[txpad] = tx_bit_r;
    pad_oe_o[txpad] = (is_host && enabled) || drive_miso;
  end
  assign rdata_o = rdata_r;
  assign sck_o = sck_int_r;
  assign sck_oe_o = is_host && enabled;
  assign sel_out_o = sel_out_r;
  assign irq_o = |(flag_r & ien_r);
  assign wake_o = is_client ? (flag_r[`SPI_F_RXC] && (ctrla_r[`SPI_A_RUNSTBY] || addr_ok_r)) : irq_o;
  // Host core clock may stop only once idle.
  wire logic core_stop_ok = is_host && sleeping_r && !ctrla_r[`SPI_A_RUNSTBY] && st_r == ST_IDLE;
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
      core_stop_r <= 1'b0;
    else
      core_stop_r <= core_stop_ok;
  end
endmodule

// *** spi_host_client_transfer_asserts.sv ***
// Purpose: Port-level checks of the dual-role serial port in host use.
// Assumes: Clock polarity 0 and no soft reset during checked traffic.
// Notes: Shadow registers follow the strobe port so no internal signal is needed.
`timescale 1ns/1ps
`include "spi_hc_map.svh"
module spi_hc_checker #(
  parameter int DW = 32
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Register writes.
  input wire logic [7:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic wr_i,
  // Observed outputs.
  input wire logic irq_o,
  input wire logic sel_out_o,
  input wire logic sck_o,
  input wire logic sck_oe_o
);
  logic en_r;
  logic host_r;
  logic pol_r;
  logic nine_r;
  logic [7:0] baud_r;
  logic [2:0] ien_r;
  logic [8:0] hi_cnt_r;
  logic [5:0] rise_cnt_r;
  logic sck_q_r;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);

  // Shadow of the settings; protected fields move only while disabled, as in the device.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      en_r <= 1'b0;
      host_r <= 1'b0;
      pol_r <= 1'b0;
      nine_r <= 1'b0;
      baud_r <= 8'h00;
      ien_r <= 3'h0;
    end
    else if (wr_i)
    begin
      if (addr_i == `SPI_CTRLA_OFS)
        en_r <= wdata_i[`SPI_A_ENABLE];
      if (addr_i == `SPI_CTRLA_OFS && !en_r)
      begin
        host_r <= wdata_i[`SPI_A_MODE_LO+:3] == `SPI_MODE_HOST;
        pol_r <= wdata_i[`SPI_A_POL];
      end
      if (addr_i == `SPI_CTRLB_OFS && !en_r)
        nine_r <= wdata_i[`SPI_B_CSIZE_LO+:3] == `SPI_CSIZE_9;
      if (addr_i == `SPI_BAUD_OFS && !en_r)
        baud_r <= wdata_i[7:0];
      if (addr_i == `SPI_IEN_SET_OFS)
        ien_r <= ien_r | wdata_i[2:0];
      if (addr_i == `SPI_IEN_CLR_OFS)
        ien_r <= ien_r & ~wdata_i[2:0];
    end
  end

  // High time of the host clock and its rises per select window.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rstn_i)
    begin
      hi_cnt_r <= 9'h000;
      rise_cnt_r <= 6'h00;
      sck_q_r <= 1'b0;
    end
    else
    begin
      sck_q_r <= sck_o;
      hi_cnt_r <= sck_o ? hi_cnt_r + 9'h001 : 9'h000;
      if (sel_out_o)
        rise_cnt_r <= 6'h00;
      else if (sck_o && !sck_q_r)
        rise_cnt_r <= rise_cnt_r + 6'h01;
    end
  end

  // The empty flag needs three cycles after the move before it shows.
  sequence s_empty_wait;
    !irq_o [*3];
  endsequence
  sequence s_empty_up;
    ##[1:4] irq_o;
  endsequence

  property p_sel_write;
    wr_i && addr_i == `SPI_SLEEP_OFS |=> sel_out_o == $past(wdata_i[0]);
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("select output differs from written value");
  property p_sel_fall;
    $fell(sel_out_o) |-> $past(wr_i) && $past(addr_i) == `SPI_SLEEP_OFS;
  endproperty
  a_sel_fall: assert property (p_sel_fall)
    else $error("select output fell without a write");
  property p_irq_masked;
    ien_r == 3'h0 |-> !irq_o;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("request line high with all sources disabled");
  property p_irq_clear;
    wr_i && addr_i == `SPI_IEN_CLR_OFS && wdata_i[2:0] == 3'h7 |=> !irq_o;
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("request line high after disabling all sources");
  property p_empty_delay;
    wr_i && addr_i == `SPI_DATA_OFS && en_r && host_r && ien_r == 3'h1 |=> s_empty_wait ##0 s_empty_up;
  endproperty
  a_empty_delay: assert property (p_empty_delay)
    else $error("empty request timing wrong after data write");
  property p_enable_sync;
    wr_i && addr_i == `SPI_CTRLA_OFS && wdata_i[`SPI_A_ENABLE] && !en_r
      && wdata_i[`SPI_A_MODE_LO+:3] == `SPI_MODE_HOST |=> !sck_oe_o ##[1:4] sck_oe_o;
  endproperty
  a_enable_sync: assert property (p_enable_sync)
    else $error("clock enable did not pass the crossing delay");
  property p_sck_high;
    $fell(sck_o) && host_r && !pol_r |-> hi_cnt_r == {1'b0, baud_r} + 9'h001;
  endproperty
  a_sck_high: assert property (p_sck_high)
    else $error("serial clock high time differs from divider");
  property p_char_bits;
    $rose(sel_out_o) && host_r && !pol_r |-> rise_cnt_r % (nine_r ? 6'h09 : 6'h08) == 6'h00;
  endproperty
  a_char_bits: assert property (p_char_bits)
    else $error("clock rises per transaction not whole characters");
endmodule

bind spi_host_client_transfer spi_hc_checker #(.DW(DW)) i_spi_hc_checker (.clk_sys_i, .rstn_i, .addr_i,
  .wdata_i, .wr_i, .irq_o, .sel_out_o, .sck_o, .sck_oe_o);

// *** spi_client_model.sv ***
// Purpose: Behavioural far-side client for host transfers.
// Assumes: Polarity 0, phase 0, top bit first, eight-bit characters.
// Notes: The reply line has no pull, so when deselected it shows the inverse of its last bit.
`timescale 1ns/1ps
module spi_client_model (
  // Serial lines.
  input wire logic sck_i,
  input wire logic sel_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  // Reply and last character taken.
  input wire logic [7:0] tx_char_i,
  output logic [7:0] rx_char_o
);
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  int bit_cnt;

  // Start quiet.
  initial
  begin
    miso_o = 1'b0;
    rx_char_o = 8'h00;
    rx_sh = 8'h00;
    bit_cnt = 0;
  end
  // Selection puts the top bit out before the first edge.
  always @(negedge sel_n_i)
  begin
    tx_sh = tx_char_i;
    miso_o = tx_sh[7];
    bit_cnt = 0;
  end
  // Sample on the leading rising edge; a full character is published.
  always @(posedge sck_i)
    if (!sel_n_i)
    begin
      rx_sh = {rx_sh[6:0], mosi_i};
      bit_cnt = bit_cnt + 1;
      if (bit_cnt == 8)
      begin
        rx_char_o = rx_sh;
        bit_cnt = 0;
      end
    end
  // Change on the trailing edge, reloading at a character boundary.
  always @(negedge sck_i)
    if (!sel_n_i)
    begin
      tx_sh = (bit_cnt == 0) ? tx_char_i : {tx_sh[6:0], 1'b0};
      miso_o = tx_sh[7];
    end
  // Released line drifts away from the last value.
  always @(posedge sel_n_i)
    miso_o = ~miso_o;
endmodule

// *** tb_spi_host_client_transfer.sv ***
// Purpose: Self-checking bench of host transfers, flags, request line and overflow.
// Assumes: Reply on pad 3, data out on pad 0; client inputs held idle.
// Notes: Expected characters are worked out by hand from the bit order.
`timescale 1ns/1ps
`include "spi_hc_map.svh"
module tb_spi_host_client_transfer;
  logic clk_sys_i;
  logic rstn_i;
  logic [7:0] addr_i;
  logic [31:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic [31:0] rdata_o;
  logic irq_o;
  logic sel_out_o;
  logic sck_o;
  logic sck_oe_o;
  logic [3:0] pad_i;
  logic [3:0] pad_o;
  logic [3:0] pad_oe_o;
  logic miso;
  logic wake;
  logic [7:0] peer_rx;
  logic [31:0] rv;
  logic [31:0] cfg [3] = '{32'h0030000C, 32'h4030000C, 32'h0000000C};
  logic [7:0] got_exp [3] = '{8'h6E, 8'h76, 8'h1B};
  logic [7:0] peer_exp [3] = '{8'h1B, 8'hD8, 8'h1B};
  int bad_count;
  int checked;

  // Driven pads show themselves; pad 3 carries the reply; other idle pads show the inverse of their output.
  always_comb
    for (int k = 0; k < 4; k++)
      pad_i[k] = pad_oe_o[k] ? pad_o[k] : (k == 3 ? miso : ~pad_o[k]);

  spi_host_client_transfer #(.DW(32)) i_spi_host_client_transfer (.clk_sys_i, .rstn_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .sleep_i(1'b0), .irq_o, .wake_o(wake), .sel_out_o, .sck_i(1'b0), .sck_o, .sck_oe_o,
    .sel_i(1'b1), .pad_i, .pad_o, .pad_oe_o);
  spi_client_model i_spi_client_model (.sck_i(sck_oe_o ? sck_o : 1'b0), .sel_n_i(sel_out_o),
    .mosi_i(pad_i[0]), .miso_o(miso), .tx_char_i(8'h6E), .rx_char_o(peer_rx));

  // System clock of 100 ns.
  initial
  begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    @(posedge clk_sys_i);
    d = rdata_o;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (exp !== got)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Disable first: protected fields are discarded while enabled.
  task automatic setup(input logic [31:0] a);
    wr(`SPI_CTRLA_OFS, a);
    repeat (6) @(posedge clk_sys_i);
    wr(`SPI_CTRLA_OFS, a);
    wr(`SPI_CTRLB_OFS, 32'h00020000);
    wr(`SPI_BAUD_OFS, 32'h00000003);
    wr(`SPI_CTRLA_OFS, a | 32'h00000002);
    repeat (4) @(posedge clk_sys_i);
  endtask

  // One character, bounded wait for transmit done, then its clear.
  task automatic xfer(input logic [7:0] c);
    int n;
    n = 0;
    rv = 32'h00000000;
    wr(`SPI_DATA_OFS, {24'h000000, c});
    while (!rv[`SPI_F_TXC] && n < 300)
    begin
      rd(`SPI_IFLAG_OFS, rv);
      n++;
    end
    chk("flags", 32'h00000007, rv & 32'h00000007);
    wr(`SPI_IFLAG_OFS, 32'h00000002);
    rd(`SPI_IFLAG_OFS, rv);
    chk("done clear", 32'h00000000, rv & 32'h00000002);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Cut a hang short well beyond the expected thousand or so cycles.
  initial
  begin
    repeat (40000) @(posedge clk_sys_i);
    bad_count++;
    $display("ERROR watchdog expected finish seen hang");
    wrap_up();
  end

  // Main sequence.
  initial
  begin
    rstn_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 32'h00000000;
    wr_i = 1'b0;
    rd_i = 1'b0;
    bad_count = 0;
    checked = 0;
    repeat (16) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    rd(`SPI_CTRLA_OFS, rv);
    chk("control reset", 32'h00000000, rv);
    chk("select idle", 32'h00000001, {31'h0, sel_out_o});
    rd(8'h30, rv);
    chk("unmapped", 32'h00000000, rv);
    for (int i = 0; i < 3; i++)
    begin
      setup(cfg[i]);
      if (i == 0)
        wr(`SPI_IEN_SET_OFS, 32'h00000001);
      wr(`SPI_SLEEP_OFS, 32'h00000000);
      xfer(8'h1B);
      wr(`SPI_SLEEP_OFS, 32'h00000001);
      rd(`SPI_DATA_OFS, rv);
      chk("rx char", {24'h000000, got_exp[i]}, rv);
      chk("peer char", {24'h000000, peer_exp[i]}, {24'h000000, peer_rx});
      @(negedge clk_sys_i);
      chk("irq", {31'h0, i == 0}, {31'h0, irq_o});
      chk("wake", {31'h0, i == 0}, {31'h0, wake});
      wr(`SPI_IEN_CLR_OFS, 32'h00000007);
      @(negedge clk_sys_i);
      chk("irq off", 32'h00000000, {31'h0, irq_o});
      $display("transfer test %0d done", i);
    end
    wr(`SPI_BAUD_OFS, 32'h00000055);
    rd(`SPI_BAUD_OFS, rv);
    chk("divider locked", 32'h00000003, rv & 32'h000000FF);
    setup(32'h0030010C);
    for (int r = 0; r < 2; r++)
    begin
      wr(`SPI_SLEEP_OFS, 32'h00000000);
      repeat (3) xfer(8'h1B);
      wr(`SPI_SLEEP_OFS, 32'h00000001);
      rd(`SPI_STATUS_OFS, rv);
      chk("overflow", 32'h00000004, rv & 32'h00000004);
      if (r == 0)
      begin
        repeat (2)
        begin
          rd(`SPI_DATA_OFS, rv);
          chk("drain", 32'h0000006E, rv);
        end
        rd(`SPI_IFLAG_OFS, rv);
        chk("drained", 32'h00000000, rv & 32'h00000004);
        rd(`SPI_STATUS_OFS, rv);
        chk("overflow held", 32'h00000004, rv & 32'h00000004);
        wr(`SPI_STATUS_OFS, 32'h00000004);
      end
      else
      begin
        wr(`SPI_CTRLB_OFS, 32'h00000000);
        repeat (6) @(posedge clk_sys_i);
      end
      rd(`SPI_STATUS_OFS, rv);
      chk("overflow clear", 32'h00000000, rv & 32'h00000004);
      $display("overflow test %0d done", r);
    end
    wrap_up();
  end
endmodule
